// file: logic/mac_pause_flow_cfg.svh
// offsets, field positions, reset values and timing counts of the pause flow block
`ifndef MAC_PAUSE_FLOW_CFG_SVH
`define MAC_PAUSE_FLOW_CFG_SVH

// register index as printed; byte address is four times the index
`define MPF_FLOW_IDX 8'h08
`define MPF_FLOW_ADDR (`MPF_FLOW_IDX * 4)
`define MPF_FLOW_RESET 32'h00000000

// field positions
`define MPF_DUR_LSB 16
`define MPF_DUR_MSB 31
`define MPF_PASS_BIT 2
`define MPF_EN_BIT 1
`define MPF_BUSY_BIT 0

// slot time in bit times, bit times in ns, clock period in ns
`define MPF_SLOT_BITS 512
`define MPF_BIT_NS_100 10
`define MPF_BIT_NS_10 100
`define MPF_CLK_NS 20
`define MPF_SLOT_CYC_100 ((`MPF_SLOT_BITS * `MPF_BIT_NS_100) / `MPF_CLK_NS)
`define MPF_SLOT_CYC_10 ((`MPF_SLOT_BITS * `MPF_BIT_NS_10) / `MPF_CLK_NS)

`endif

// file: logic/mac_pause_flow_pkg.sv
// types shared by the pause flow control block
package mac_pause_flow_pkg;

  typedef enum logic [1:0] {
    FLOW_IDLE,
    FLOW_SEND,
    FLOW_BACKP
  } flow_state_t;

  // one received frame, reported at its end by the receive path
  typedef struct packed {
    logic done;
    logic pauseValid;
    logic [15:0] quanta;
    logic addrPass;
    logic filterOverride;
  } rx_frame_t;

  // receive status handed to the application
  typedef struct packed {
    logic valid;
    logic filterPass;
    logic isPause;
  } rx_status_t;

  // receive data byte
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } rx_byte_t;

  // pause frame request towards the transmitter
  typedef struct packed {
    logic req;
    logic [15:0] pauseTime;
  } tx_pause_t;

endpackage

// file: logic/pause_slot_timer.sv
// counts a received pause time down in slot units
`timescale 1ns/100ps
`default_nettype none

module pause_slot_timer #(
  parameter int QW = 16,
  parameter int CW = 12
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic clear,
  input wire logic load,
  input wire logic [QW-1:0] quanta,
  input wire logic [CW-1:0] slotCycles,
  output logic active
);

  logic [QW-1:0] left_q;
  logic [QW-1:0] left_d;
  logic [CW-1:0] cyc_q;
  logic [CW-1:0] cyc_d;
  wire slotEnd = (cyc_q == '0);
  wire [CW-1:0] cycTop = slotCycles - CW'(1);

  assign active = (left_q != '0);

  always_comb
  begin
    left_d = left_q;
    cyc_d = cyc_q;
    if (clear)
    begin
      left_d = '0;
      cyc_d = '0;
    end
    else if (load)
    begin
      left_d = quanta;
      cyc_d = cycTop;
    end
    else if (active)
    begin
      if (slotEnd)
      begin
        left_d = left_q - QW'(1);
        cyc_d = cycTop;
      end
      else
      begin
        cyc_d = cyc_q - CW'(1);
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      left_q <= '0;
      cyc_q <= '0;
    end
    else
    begin
      left_q <= left_d;
      cyc_q <= cyc_d;
    end
  end

endmodule

`default_nettype wire

// file: logic/mac_pause_flow_control.sv
// pause frame generation, pause reception and back pressure of a 10/100 mac
`timescale 1ns/100ps
`default_nettype none
`include "mac_pause_flow_cfg.svh"

module mac_pause_flow_control
  import mac_pause_flow_pkg::*;
#(
  parameter int AW = 8,
  parameter int QW = 16
) (
  input wire logic clock,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // mac mode from the mac control logic
  input wire logic fullDuplex,
  input wire logic speed100,
  input wire logic txEnable,
  // triggers from the automatic flow configuration logic
  input wire logic afcPauseReq,
  input wire logic afcBackpressureReq,
  // transmitter side
  output tx_pause_t txPause,
  input wire logic pauseFrameSent,
  output logic backpressure,
  output logic txStall,
  // receive side
  input wire rx_frame_t rxFrame,
  input wire rx_byte_t rxByteIn,
  output rx_status_t rxStatus,
  output rx_byte_t rxByteOut
);

  localparam int CW = 12;
  localparam logic [AW-1:0] FLOW_ADDR = AW'(`MPF_FLOW_ADDR);
  localparam logic [CW-1:0] SLOT_CYC_100 = CW'(`MPF_SLOT_CYC_100);
  localparam logic [CW-1:0] SLOT_CYC_10 = CW'(`MPF_SLOT_CYC_10);
  localparam logic [31:0] FLOW_RESET = `MPF_FLOW_RESET;

  // register fields
  logic [QW-1:0] duration_q;
  logic passCtrl_q;
  logic flowEn_q;

  // apb decode
  wire setupPhase = psel && !penable;
  wire accessPhase = psel && penable;
  wire hitFlow = (paddr == FLOW_ADDR);
  wire flowWrite = accessPhase && pwrite && hitFlow;

  // flow state
  flow_state_t state_q;
  flow_state_t state_d;
  logic [QW-1:0] pauseTime_q;
  logic [31:0] prdata_q;

  // state decode shared by the outputs and the busy bit
  wire inIdle = (state_q == FLOW_IDLE);
  wire inSend = (state_q == FLOW_SEND);
  wire inBackp = (state_q == FLOW_BACKP);

  // busy follows the outputs, so it falls with back pressure in the same cycle
  wire flowBusy = txPause.req || backpressure;

  // read view of the flow register; reserved bits are zero
  wire [31:0] flowRead = {duration_q, 13'h0000, passCtrl_q, flowEn_q, flowBusy};

  // read data is taken in the setup cycle, so every access completes without a wait
  wire [31:0] readMux = hitFlow ? flowRead : 32'h00000000;

  assign pready = 1'b1;
  // only the flow register is mapped; any other offset answers with an error
  assign pslverr = accessPhase && !hitFlow;
  assign prdata = prdata_q;

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      prdata_q <= 32'h00000000;
    end
    else if (setupPhase)
    begin
      prdata_q <= readMux;
    end
  end

  // writes store only the duration, pass and enable fields
  wire [QW-1:0] durationWr = pwdata[`MPF_DUR_MSB:`MPF_DUR_LSB];
  wire passWr = pwdata[`MPF_PASS_BIT];
  wire enWr = pwdata[`MPF_EN_BIT];

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      duration_q <= FLOW_RESET[`MPF_DUR_MSB:`MPF_DUR_LSB];
    end
    else if (flowWrite)
    begin
      duration_q <= durationWr;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      passCtrl_q <= FLOW_RESET[`MPF_PASS_BIT];
    end
    else if (flowWrite)
    begin
      passCtrl_q <= passWr;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      flowEn_q <= FLOW_RESET[`MPF_EN_BIT];
    end
    else if (flowWrite)
    begin
      flowEn_q <= enWr;
    end
  end

  // start conditions; only the automatic flow config triggers them
  wire startPause = txEnable && fullDuplex && afcPauseReq;
  wire startBackp = txEnable && !fullDuplex && flowEn_q && afcBackpressureReq;
  wire keepBackp = startBackp;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      FLOW_IDLE:
      begin
        if (startPause)
        begin
          state_d = FLOW_SEND;
        end
        else if (startBackp)
        begin
          state_d = FLOW_BACKP;
        end
      end
      FLOW_SEND:
      begin
        // busy ends once the frame is on the cable
        if (pauseFrameSent || !txEnable)
        begin
          state_d = FLOW_IDLE;
        end
      end
      FLOW_BACKP:
      begin
        if (!keepBackp)
        begin
          state_d = FLOW_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      state_q <= FLOW_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // pause time captured when the frame request starts
  wire loadPauseTime = inIdle && startPause;
  logic [QW-1:0] pauseTime_d;

  always_comb
  begin
    pauseTime_d = pauseTime_q;
    if (loadPauseTime)
    begin
      pauseTime_d = duration_q;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      pauseTime_q <= '0;
    end
    else
    begin
      pauseTime_q <= pauseTime_d;
    end
  end

  // the request drops at once when the transmitter is switched off
  assign txPause.req = inSend && txEnable;
  assign txPause.pauseTime = pauseTime_q;
  assign backpressure = inBackp && txEnable;

  // pause reception
  wire rxHonour = flowEn_q && fullDuplex;
  wire rxPauseHit = rxFrame.done && rxFrame.pauseValid && rxHonour;
  wire [CW-1:0] slotCycles = speed100 ? SLOT_CYC_100 : SLOT_CYC_10;
  // leaving full duplex or clearing the enable cancels a running stall
  wire timerClear = !rxHonour;
  // a pause frame during a stall reloads the count, so the latest quanta wins
  wire timerLoad = rxPauseHit;

  pause_slot_timer #(
    .QW(QW),
    .CW(CW)
  ) slotTimer (
    .clock(clock),
    .rstn(rstn),
    .clear(timerClear),
    .load(timerLoad),
    .quanta(rxFrame.quanta),
    .slotCycles(slotCycles),
    .active(txStall)
  );

  // receive status: filter indication for each frame
  wire isPauseFrame = rxFrame.pauseValid;
  wire pauseFilter = rxFrame.filterOverride ? rxFrame.addrPass : passCtrl_q;
  wire frameFilter = isPauseFrame ? pauseFilter : rxFrame.addrPass;
  rx_status_t rxStatus_d;

  // filter and type bits stay until the next frame ends; valid is a single pulse
  always_comb
  begin
    rxStatus_d = rxStatus;
    rxStatus_d.valid = rxFrame.done;
    if (rxFrame.done)
    begin
      rxStatus_d.filterPass = frameFilter;
      rxStatus_d.isPause = isPauseFrame;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      rxStatus <= '0;
    end
    else
    begin
      rxStatus <= rxStatus_d;
    end
  end

  // data of every frame is handed on, whatever its filter result
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      rxByteOut <= '0;
    end
    else
    begin
      rxByteOut <= rxByteIn;
    end
  end

endmodule

`default_nettype wire

// file: test/mac_pause_flow_properties.sv
// concurrent checks on the ports of the pause flow control block
`timescale 1ns/100ps
`default_nettype none

module mac_pause_flow_properties
  import mac_pause_flow_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pslverr,
  input wire logic fullDuplex,
  input wire logic txEnable,
  input wire logic afcPauseReq,
  input wire logic afcBackpressureReq,
  input wire tx_pause_t txPause,
  input wire logic pauseFrameSent,
  input wire logic backpressure,
  input wire logic txStall,
  input wire rx_frame_t rxFrame,
  input wire rx_byte_t rxByteIn,
  input wire rx_status_t rxStatus,
  input wire rx_byte_t rxByteOut
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  sequence sendDone;
    txPause.req && pauseFrameSent;
  endsequence
  a_apb_unmapped: assert property (psel && penable && paddr != 8'h20 |-> pslverr)
    else $error("unmapped access without error");
  a_pause_end: assert property (sendDone |=> !txPause.req)
    else $error("pause request kept after frame sent");
  a_pause_trig: assert property ($rose(txPause.req) |-> $past(afcPauseReq && fullDuplex))
    else $error("pause request without trigger");
  a_tx_off: assert property (!txEnable |-> !txPause.req && !backpressure)
    else $error("activity with transmitter off");
  a_bp_cause: assert property (backpressure |-> $past(afcBackpressureReq && !fullDuplex))
    else $error("back pressure without request");
  a_stall_cause: assert property ($rose(txStall) |-> $past(rxFrame.done && fullDuplex))
    else $error("stall without pause frame");
  a_half_nostall: assert property (!fullDuplex |=> !txStall)
    else $error("stall in half duplex");
  a_status_next: assert property (rxFrame.done |=> rxStatus.valid)
    else $error("no status after frame");
  a_byte_copy: assert property ($past(rstn) |-> rxByteOut == $past(rxByteIn))
    else $error("data byte not passed");
  a_filter_mode: assert property (rxFrame.done && rxFrame.pauseValid && rxFrame.filterOverride
    |=> rxStatus.filterPass == $past(rxFrame.addrPass))
    else $error("filter mode ignored");
endmodule

bind mac_pause_flow_control mac_pause_flow_properties props (.clock, .rstn, .psel, .penable,
  .paddr, .pslverr, .fullDuplex, .txEnable, .afcPauseReq, .afcBackpressureReq, .txPause,
  .pauseFrameSent, .backpressure, .txStall, .rxFrame, .rxByteIn, .rxStatus, .rxByteOut);

`default_nettype wire

// file: test/pause_tx_partner.sv
// transmitter and cable model that sends requested pause frames after a gap
`timescale 1ns/100ps
`default_nettype none

module pause_tx_partner
  import mac_pause_flow_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [3:0] gap,
  input wire tx_pause_t txPause,
  output logic pauseFrameSent,
  output logic [15:0] sentTime_q
);
  logic [3:0] cnt_q;
  always_ff @(posedge clock)
  begin
    if (!rstn || !txPause.req || pauseFrameSent)
    begin
      cnt_q <= 4'h0;
      pauseFrameSent <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_q + 4'h1;
      pauseFrameSent <= (cnt_q == gap);
      sentTime_q <= txPause.pauseTime;
    end
  end
endmodule

`default_nettype wire

// file: test/mac_pause_flow_control_tb.sv
// self-checking bench of the pause flow control block
`timescale 1ns/100ps
`default_nettype none

module mac_pause_flow_control_tb
  import mac_pause_flow_pkg::*;
;
  logic clock = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, pauseFrameSent, backpressure, txStall, slvErr;
  logic fullDuplex = 1'b1, speed100 = 1'b1, txEnable = 1'b1, afcPauseReq = 1'b0;
  logic afcBackpressureReq = 1'b0;
  logic [3:0] gap = 4'h9;
  logic [15:0] sentTime;
  tx_pause_t txPause;
  rx_frame_t rxFrame = '0;
  rx_byte_t rxByteIn = '0;
  rx_status_t rxStatus;
  rx_byte_t rxByteOut;
  int error_cnt = 0, checks_done = 0, n;
  logic [31:0] wr[3] = '{32'hfffffffe, 32'h12340004, 32'h00050000};
  logic [31:0] ex[3] = '{32'hffff0006, 32'h12340004, 32'h00050000};

  always #10 clock = ~clock;

  mac_pause_flow_control uut (.clock, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .fullDuplex, .speed100, .txEnable, .afcPauseReq,
    .afcBackpressureReq, .txPause, .pauseFrameSent, .backpressure, .txStall, .rxFrame,
    .rxByteIn, .rxStatus, .rxByteOut);
  pause_tx_partner far (.clock, .rstn, .gap, .txPause, .pauseFrameSent, .sentTime_q(sentTime));

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    r = prdata;
    slvErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rxf(input rx_frame_t f, input logic [2:0] e);
    @(posedge clock);
    rxFrame <= f;
    rxByteIn <= {1'b1, f.quanta[7:0]};
    @(posedge clock);
    rxFrame <= '0;
    rxByteIn <= '0;
    @(negedge clock);
    chk(32'(rxStatus), {29'h0, e});
    chk(32'(rxByteOut), {23'h0, 1'b1, f.quanta[7:0]});
    for (n = 0; txStall === 1'b1 && n < 3000; n++)
      @(negedge clock);
  endtask

  initial
  begin
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    apb(1'b0, 8'h20, 32'h0);
    chk(r, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, 8'h20, wr[i]);
      apb(1'b0, 8'h20, 32'h0);
      chk(r, ex[i]);
      chk({31'h0, slvErr}, 32'h0);
    end
    apb(1'b1, 8'h14, 32'hffffffff);
    apb(1'b0, 8'h14, 32'h0);
    chk(r, 32'h0);
    chk({31'h0, slvErr}, 32'h1);
    // bias with flow enable off: no back pressure in half duplex
    fullDuplex <= 1'b0;
    afcBackpressureReq <= 1'b1;
    apb(1'b0, 8'h20, 32'h0);
    chk(r, 32'h00050000);
    chk({31'h0, backpressure}, 32'h0);
    apb(1'b1, 8'h20, 32'h00050002);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, backpressure & r[0]}, 32'h1);
    afcBackpressureReq <= 1'b0;
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, backpressure | r[0]}, 32'h0);
    fullDuplex <= 1'b1;
    afcPauseReq <= 1'b1;
    @(posedge clock);
    afcPauseReq <= 1'b0;
    apb(1'b0, 8'h20, 32'h0);
    chk(r, 32'h00050003);
    repeat (12) @(posedge clock);
    apb(1'b0, 8'h20, 32'h0);
    chk({sentTime, r[15:0]}, 32'h00050002);
    txEnable <= 1'b0;
    afcPauseReq <= 1'b1;
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, txPause.req | r[0]}, 32'h0);
    txEnable <= 1'b1;
    afcPauseReq <= 1'b0;
    rxf('{1'b1, 1'b1, 16'h0002, 1'b0, 1'b0}, 3'b101);
    chk(n, 32'd512);
    apb(1'b1, 8'h20, 32'h00050004);
    rxf('{1'b1, 1'b1, 16'h0002, 1'b0, 1'b0}, 3'b111);
    chk(n, 32'd0);
    rxf('{1'b1, 1'b1, 16'h0002, 1'b0, 1'b1}, 3'b101);
    apb(1'b1, 8'h20, 32'h00050002);
    speed100 <= 1'b0;
    rxf('{1'b1, 1'b1, 16'h0001, 1'b0, 1'b0}, 3'b101);
    chk(n, 32'd2560);
    @(posedge clock);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    apb(1'b0, 8'h20, 32'h0);
    chk(r, 32'h0);
    report_and_stop();
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    report_and_stop();
  end
endmodule

`default_nettype wire
